// file: sim/card_host_signal_interface_bench.sv
// Purpose: Self-checking bench for cfh_host against a card model
// Assumes: One access at a time, done awaited under a bound
// Notes:   Random fields from a fixed-seed shift register
`timescale 1ns/1ns
`default_nettype none
module card_host_signal_interface_bench;
  import cfh_pkg::*;
  logic mclk, arst_n, cmd_req, cmd_write, cmd_attr, cmd_alt, cmd_word, cfg_master;
  logic [1:0] cmd_mode, mode_now, cap_ce;
  logic [10:0] cmd_addr, pin_a, cap_a;
  logic [15:0] cmd_wdata, cmd_rdata, pin_d_in, pin_d_out, card_d;
  logic cmd_busy, cmd_done, card_seated, slave_present, diag_passed, status_change;
  logic pin_ce1_n, pin_ce2_n, pin_oe_n, pin_we_n, pin_iord_n, pin_iowr_n, pin_reg_n;
  logic pin_csel_n, pin_d_oe_lo, pin_d_oe_hi, pin_cd1_n, pin_cd2_n, cap_oe, cap_reg;
  logic h1_out, h1_oe, h2_out, h2_oe, c1_out, c1_oe, c2_out, c2_oe, master;
  logic present, stschg_req, diag_req, dasp_req;
  logic [31:0] rnd;
  logic [15:0] expv;
  int n_mismatch, samples_checked;
  ////////////////////////////////////////////////////////////////////////
  // Wire resolution: pull-ups on the status pins
  assign pin_d_in = {pin_d_oe_hi ? pin_d_out[15:8] : card_d[15:8],
                     pin_d_oe_lo ? pin_d_out[7:0] : card_d[7:0]};
  cfh_host u_cfh_host (.mclk(mclk), .arst_n(arst_n), .cmd_req(cmd_req),
    .cmd_write(cmd_write), .cmd_mode(cmd_mode), .cmd_attr(cmd_attr), .cmd_alt(cmd_alt),
    .cmd_word(cmd_word), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cfg_master(cfg_master), .cmd_busy(cmd_busy), .cmd_done(cmd_done),
    .cmd_rdata(cmd_rdata), .card_seated(card_seated), .slave_present(slave_present),
    .diag_passed(diag_passed), .status_change(status_change), .pin_a(pin_a),
    .pin_ce1_n(pin_ce1_n), .pin_ce2_n(pin_ce2_n), .pin_oe_n(pin_oe_n),
    .pin_we_n(pin_we_n), .pin_iord_n(pin_iord_n), .pin_iowr_n(pin_iowr_n),
    .pin_reg_n(pin_reg_n), .pin_csel_n(pin_csel_n), .pin_d_in(pin_d_in),
    .pin_d_out(pin_d_out), .pin_d_oe_lo(pin_d_oe_lo), .pin_d_oe_hi(pin_d_oe_hi),
    .pin_cd1_n(pin_cd1_n), .pin_cd2_n(pin_cd2_n),
    .pin_stat1_in(h1_oe ? h1_out : (c1_oe ? c1_out : 1'b1)),
    .pin_stat1_out(h1_out), .pin_stat1_oe(h1_oe),
    .pin_stat2_in(h2_oe ? h2_out : (c2_oe ? c2_out : 1'b1)),
    .pin_stat2_out(h2_out), .pin_stat2_oe(h2_oe));
  cfh_card_model u_cfh_card_model (.mclk(mclk), .mode(mode_now), .present(present),
    .stschg_req(stschg_req), .diag_req(diag_req), .dasp_req(dasp_req), .a(pin_a),
    .ce1_n(pin_ce1_n), .ce2_n(pin_ce2_n), .oe_n(pin_oe_n), .we_n(pin_we_n),
    .iord_n(pin_iord_n), .iowr_n(pin_iowr_n), .reg_n(pin_reg_n), .csel_n(pin_csel_n),
    .d_in(pin_d_in), .d_out(card_d), .cd1_n(pin_cd1_n), .cd2_n(pin_cd2_n),
    .stat1_out(c1_out), .stat1_oe(c1_oe), .stat2_out(c2_out), .stat2_oe(c2_oe),
    .master(master));
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Pin picture taken mid-strobe
  always @(negedge mclk)
  begin
    if (!pin_iord_n || !pin_iowr_n || !pin_we_n || (!pin_oe_n && mode_now == CFH_MODE_MEM))
    begin
      cap_a   = pin_a;
      cap_oe  = pin_oe_n;
      cap_reg = pin_reg_n;
      cap_ce  = {pin_ce2_n, pin_ce1_n};
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] exp_rd(input logic [1:0] m, input logic alt, word,
                                         input logic [10:0] a, input logic [15:0] wd);
    logic wide;
    wide = (m == CFH_MODE_IDE) ? (!alt && a[2:0] == 3'h0) : word;
    exp_rd = wide ? wd : {8'h00, wd[7:0]};
  endfunction
  task automatic chk(input string name, input logic [15:0] exp, got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic access(input logic wr, attr, alt, word, input logic [10:0] a,
                        input logic [15:0] wd);
    int k;
    @(posedge mclk);
    cmd_req   <= 1'b1;
    cmd_write <= wr;
    cmd_mode  <= mode_now;
    cmd_attr  <= attr;
    cmd_alt   <= alt;
    cmd_word  <= word;
    cmd_addr  <= a;
    cmd_wdata <= wd;
    @(posedge mclk);
    cmd_req <= 1'b0;
    for (k = 0; k < 40 && cmd_done !== 1'b1; k++)
      @(negedge mclk);
    chk("cmd_done", 16'h0001, {15'h0000, cmd_done});
    chk("cmd_busy", 16'h0000, {15'h0000, cmd_busy});
    chk("idle enables", 16'h0003, {14'h0000, pin_ce2_n, pin_ce1_n});
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_mismatch++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {arst_n, cmd_req, cmd_write, cmd_attr, cmd_alt, cmd_word, cfg_master} = 7'h00;
    {present, stschg_req, diag_req, dasp_req} = 4'h0;
    cmd_mode = 2'h0;
    mode_now = 2'h0;
    cmd_addr = 11'h000;
    cmd_wdata = 16'h0000;
    rnd = 32'h0001590A;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      present <= i[0];
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk("card_seated", {15'h0000, i[0]}, {15'h0000, card_seated});
    end
    $display("test detect done");
    for (int m = 0; m < 3; m++)
    begin
      mode_now <= m[1:0];
      for (int n = 0; n < 16; n++)
      begin
        rnd = lfsr(lfsr(rnd));
        access(1'b1, m == 0 && rnd[0], m == 2 && rnd[1], rnd[2], rnd[13:3], rnd[31:16]);
        access(1'b0, m == 0 && rnd[0], m == 2 && rnd[1], rnd[2], rnd[13:3], 16'h0000);
        expv = exp_rd(m[1:0], m == 2 && rnd[1], rnd[2], rnd[13:3], rnd[31:16]);
        chk("cmd_rdata", expv, cmd_rdata);
        if (m == 2)
        begin
          chk("ide pin_a", {5'h00, 8'h00, rnd[5:3]}, {5'h00, cap_a});
          chk("ide oe_n", 16'h0000, {15'h0000, cap_oe});
          chk("ide selects", {14'h0000, rnd[1] ? 2'b01 : 2'b10}, {14'h0000, cap_ce});
        end
        else
        begin
          chk("pin_a", {5'h00, rnd[13:3]}, {5'h00, cap_a});
          chk("enables", {14'h0000, rnd[2] ? 2'b00 : 2'b10}, {14'h0000, cap_ce});
        end
        if (m == 0)
          chk("reg_n", {15'h0000, !rnd[0]}, {15'h0000, cap_reg});
      end
      for (int r = 0; r < 2; r++)
      begin
        {stschg_req, diag_req, dasp_req} <= {3{r[0]}};
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk("status_change", {15'h0000, m == 1 && r == 1}, {15'h0000, status_change});
        chk("diag_passed", {15'h0000, m == 2 && r == 1}, {15'h0000, diag_passed});
        chk("slave_present", {15'h0000, m == 2 && r == 1}, {15'h0000, slave_present});
        chk("host stat drive", 16'h0000, {14'h0000, h1_oe, h2_oe});
      end
      $display("test mode %0d done", m);
    end
    for (int c = 0; c < 2; c++)
    begin
      cfg_master <= c[0];
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk("card master", {15'h0000, c[0]}, {15'h0000, master});
    end
    mode_now <= 2'h0;
    access(1'b1, 1'b1, 1'b0, 1'b1, 11'h7FF, 16'hA5C3);
    access(1'b1, 1'b0, 1'b0, 1'b1, 11'h7FF, 16'h3C5A);
    access(1'b0, 1'b1, 1'b0, 1'b1, 11'h7FF, 16'h0000);
    chk("attr rdata", 16'hA5C3, cmd_rdata);
    access(1'b0, 1'b0, 1'b0, 1'b0, 11'h7FF, 16'h0000);
    chk("common byte", 16'h005A, cmd_rdata);
    chk("card master mem", 16'h0000, {15'h0000, master});
    $display("test corner done");
    end_sim();
  end
endmodule
`default_nettype wire

// file: sim/cfh_card_model.sv
// Purpose: Behavioural storage card facing the host controller
// Assumes: Personality given by the bench; strobes from cfh_host
// Notes:   Released bus shows the inverse of its last level
`timescale 1ns/1ns
`default_nettype none
module cfh_card_model
  import cfh_pkg::*;
(
  input  wire logic        mclk,       // Bench clock, bus keeper only
  input  wire logic [1:0]  mode,       // Card personality
  input  wire logic        present,    // Card inserted
  input  wire logic        stschg_req, // Raise status change
  input  wire logic        diag_req,   // Pull diagnostic low
  input  wire logic        dasp_req,   // Pull active/slave low
  input  wire logic [10:0] a,          // Address lines
  input  wire logic        ce1_n,      // Enable 1 / select 0
  input  wire logic        ce2_n,      // Enable 2 / select 1
  input  wire logic        oe_n,       // Output enable / mode select
  input  wire logic        we_n,       // Memory write strobe
  input  wire logic        iord_n,     // I/O read strobe
  input  wire logic        iowr_n,     // I/O write strobe
  input  wire logic        reg_n,      // Space select
  input  wire logic        csel_n,     // Cable select
  input  wire logic [15:0] d_in,       // Resolved data bus
  output logic [15:0]      d_out,      // Card data or keeper pattern
  output logic             cd1_n,      // Card detect 1
  output logic             cd2_n,      // Card detect 2
  output logic             stat1_out,  // Pin 46 level
  output logic             stat1_oe,   // Pin 46 driven
  output logic             stat2_out,  // Pin 45 level
  output logic             stat2_oe,   // Pin 45 driven
  output logic             master      // Configured as master
);
  logic [15:0] mem [0:4095];
  logic [15:0] last_ff;
  logic [11:0] idx;
  logic        ide, sel, wide, rd, wstb;
  assign ide  = (mode == CFH_MODE_IDE);
  assign idx  = ide ? {8'h00, !ce2_n, a[2:0]} : {(mode == CFH_MODE_MEM) && !reg_n, a};
  assign sel  = !ce1_n || !ce2_n;
  assign wide = ide ? (!ce1_n && a[2:0] == 3'h0) : (!ce1_n && !ce2_n);
  assign rd   = sel && ((mode == CFH_MODE_MEM) ? !oe_n : !iord_n);
  assign wstb = (mode == CFH_MODE_MEM) ? we_n : iowr_n;
  always @(posedge wstb)
  begin
    if (sel && wide)
      mem[idx] = d_in;
    else if (sel)
      mem[idx][7:0] = d_in[7:0];
  end
  always @(posedge mclk)
    last_ff <= d_in;
  // Undriven lanes never repeat the last value
  assign d_out = rd ? (wide ? mem[idx] : {~last_ff[15:8], mem[idx][7:0]}) : ~last_ff;
  assign cd1_n = !present;
  assign cd2_n = !present;
  always_comb
  begin
    stat1_out = 1'b1;
    stat1_oe  = 1'b1;
    stat2_out = 1'b1;
    stat2_oe  = 1'b1;
    if (mode == CFH_MODE_IO)
      stat1_out = !stschg_req;
    else if (ide)
    begin
      stat1_out = 1'b0;
      stat1_oe  = diag_req;
      stat2_out = 1'b0;
      stat2_oe  = dasp_req;
    end
  end
  assign master = ide && !csel_n;
endmodule
`default_nettype wire

// file: src/cfh_host.sv
// Purpose: Host controller driving a storage card's signal pins
// Assumes: Card inputs synchronous to mclk; one command at a time
// Notes:   Host never drives the two shared status pins
`timescale 1ns/1ns
`default_nettype none
module cfh_host
  import cfh_pkg::*;
(
  input  wire logic        mclk,          // 125 MHz clock
  input  wire logic        arst_n,        // Async reset, low
  input  wire logic        cmd_req,       // Start access, taken when idle
  input  wire logic        cmd_write,     // 1 write, 0 read
  input  wire logic [1:0]  cmd_mode,      // Interface personality
  input  wire logic        cmd_attr,      // Attribute space (memory mode)
  input  wire logic        cmd_alt,       // IDE: alternate register block
  input  wire logic        cmd_word,      // Word access (card modes)
  input  wire logic [10:0] cmd_addr,      // Access address
  input  wire logic [15:0] cmd_wdata,     // Write data
  input  wire logic        cfg_master,    // Configure card as master
  output logic             cmd_busy,      // Access in progress
  output logic             cmd_done,      // One-cycle completion pulse
  output logic [15:0]      cmd_rdata,     // Read data
  output logic             card_seated,   // Both detects low
  output logic             slave_present, // IDE slave seen
  output logic             diag_passed,   // IDE diagnostic passed
  output logic             status_change, // I/O status change seen
  output logic [10:0]      pin_a,         // Address lines
  output logic             pin_ce1_n,     // Enable 1 / chip select 0
  output logic             pin_ce2_n,     // Enable 2 / chip select 1
  output logic             pin_oe_n,      // Output enable / mode select
  output logic             pin_we_n,      // Memory write strobe
  output logic             pin_iord_n,    // I/O read strobe
  output logic             pin_iowr_n,    // I/O write strobe
  output logic             pin_reg_n,     // Space select
  output logic             pin_csel_n,    // Cable select
  input  wire logic [15:0] pin_d_in,      // Data bus in
  output logic [15:0]      pin_d_out,     // Data bus out
  output logic             pin_d_oe_lo,   // Drive D07..D00
  output logic             pin_d_oe_hi,   // Drive D15..D08
  input  wire logic        pin_cd1_n,     // Card detect 1
  input  wire logic        pin_cd2_n,     // Card detect 2
  input  wire logic        pin_stat1_in,  // Status pin 46 in
  output logic             pin_stat1_out, // Status pin 46 out
  output logic             pin_stat1_oe,  // Status pin 46 enable
  input  wire logic        pin_stat2_in,  // Status pin 45 in
  output logic             pin_stat2_out, // Status pin 45 out
  output logic             pin_stat2_oe   // Status pin 45 enable
);
  cfh_state_t  st_ff, nxt_st;
  cfh_mode_t   mode_ff, nxt_mode;
  logic        wr_ff, nxt_wr, word_ff, nxt_word, done_ff, nxt_done, busy_ff, nxt_busy;
  logic [10:0] a_ff, nxt_a;
  logic [15:0] dout_ff, nxt_dout, rdata_ff, nxt_rdata;
  logic        ce1_ff, nxt_ce1, ce2_ff, nxt_ce2, reg_ff, nxt_reg;
  logic        oe_ff, nxt_oe, we_ff, nxt_we, iord_ff, nxt_iord, iowr_ff, nxt_iowr;
  logic        dlo_ff, nxt_dlo, dhi_ff, nxt_dhi;
  logic        seat_ff, slave_ff, diag_ff, stchg_ff, csel_ff;
  logic        tick;
  ////////////////////////////////////////////////////////////////////////////
  // Phase timer
  cfh_tick u_tick (
    .mclk   (mclk),
    .arst_n (arst_n),
    .clr    (st_ff == CFH_ST_IDLE),
    .tick   (tick)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer
  always_comb
  begin
    nxt_st    = st_ff;
    nxt_mode  = mode_ff;
    nxt_wr    = wr_ff;
    nxt_word  = word_ff;
    nxt_a     = a_ff;
    nxt_dout  = dout_ff;
    nxt_rdata = rdata_ff;
    nxt_ce1   = ce1_ff;
    nxt_ce2   = ce2_ff;
    nxt_reg   = reg_ff;
    {nxt_we, nxt_iord, nxt_iowr} = 3'h7;
    nxt_dlo   = dlo_ff;
    nxt_dhi   = dhi_ff;
    nxt_done  = 1'b0;
    // Mode select grounded for the whole time IDE is the last mode
    // IDE mode select
    nxt_oe    = (mode_ff != CFH_MODE_IDE);
    case (st_ff)
      CFH_ST_IDLE:
      begin
        if (cmd_req)
        begin
          nxt_st   = CFH_ST_SETUP;
          nxt_mode = cfh_mode_t'(cmd_mode);
          nxt_wr   = cmd_write;
          nxt_oe   = (cmd_mode != CFH_MODE_IDE);
          if (cmd_mode == CFH_MODE_IDE)
          begin
            nxt_a   = {8'h00, cmd_addr[CFH_IDE_A_W-1:0]};
            nxt_ce1 = cmd_alt;
            nxt_ce2 = !cmd_alt;
            nxt_word = !cmd_alt && (cmd_addr[CFH_IDE_A_W-1:0] == 3'h0);
            nxt_reg  = 1'b1;
          end
          else
          begin
            nxt_a    = cmd_addr;
            nxt_ce1  = 1'b0;
            nxt_ce2  = !cmd_word;
            nxt_word = cmd_word;
            nxt_reg  = (cmd_mode == CFH_MODE_MEM) ? !cmd_attr : 1'b1;
          end
          nxt_dout = nxt_word ? cmd_wdata : {8'h00, cmd_wdata[CFH_BYTE_W-1:0]};
          nxt_dlo = cmd_write;
          nxt_dhi = cmd_write && nxt_word;
        end
      end
      CFH_ST_SETUP:
      begin
        if (tick)
        begin
          nxt_st = CFH_ST_STROBE;
        end
      end
      CFH_ST_STROBE:
      begin
        nxt_we   = !(mode_ff == CFH_MODE_MEM && wr_ff);
        nxt_oe   = (mode_ff == CFH_MODE_MEM) ? wr_ff : nxt_oe;
        nxt_iord = !(mode_ff != CFH_MODE_MEM && !wr_ff);
        nxt_iowr = !(mode_ff != CFH_MODE_MEM && wr_ff);
        if (tick)
        begin
          nxt_st   = CFH_ST_HOLD;
          nxt_oe   = (mode_ff != CFH_MODE_IDE);
          {nxt_we, nxt_iord, nxt_iowr} = 3'h7;
          if (!wr_ff)
          begin
            nxt_rdata = word_ff ? pin_d_in : {8'h00, pin_d_in[CFH_BYTE_W-1:0]};
          end
        end
      end
      CFH_ST_HOLD:
      begin
        // Data and address stay put past the rising write strobe
        // write data hold
        if (tick)
        begin
          nxt_st   = CFH_ST_IDLE;
          nxt_done = 1'b1;
          {nxt_ce1, nxt_ce2} = 2'h3;
          {nxt_dlo, nxt_dhi} = 2'h0;
        end
      end
      default:
      begin
        nxt_st = CFH_ST_IDLE;
      end
    endcase
    // Busy is registered so every top output leaves a flop or is tied to a constant
    nxt_busy = (nxt_st != CFH_ST_IDLE);
  end
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_ff    <= CFH_ST_IDLE;
      mode_ff  <= CFH_MODE_MEM;
      a_ff     <= 11'h000;
      dout_ff  <= 16'h0000;
      rdata_ff <= 16'h0000;
      {ce1_ff, ce2_ff, reg_ff, oe_ff, we_ff, iord_ff, iowr_ff} <= 7'h7F;
      {wr_ff, word_ff, dlo_ff, dhi_ff, done_ff, busy_ff} <= 6'h00;
    end
    else
    begin
      st_ff    <= nxt_st;
      mode_ff  <= nxt_mode;
      wr_ff    <= nxt_wr;
      word_ff  <= nxt_word;
      a_ff     <= nxt_a;
      dout_ff  <= nxt_dout;
      rdata_ff <= nxt_rdata;
      ce1_ff   <= nxt_ce1;
      ce2_ff   <= nxt_ce2;
      reg_ff   <= nxt_reg;
      oe_ff    <= nxt_oe;
      we_ff    <= nxt_we;
      iord_ff  <= nxt_iord;
      iowr_ff  <= nxt_iowr;
      dlo_ff   <= nxt_dlo;
      dhi_ff   <= nxt_dhi;
      done_ff  <= nxt_done;
      busy_ff  <= nxt_busy;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Card status observers
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {seat_ff, slave_ff, diag_ff, stchg_ff} <= 4'h0;
      csel_ff  <= 1'b1;
    end
    else
    begin
      seat_ff  <= !pin_cd1_n && !pin_cd2_n;
      // Shared pins are only read; the card side owns them
      // IDE handshake pins and I/O status change
      diag_ff  <= (mode_ff == CFH_MODE_IDE) && !pin_stat1_in;
      slave_ff <= (mode_ff == CFH_MODE_IDE) && !pin_stat2_in;
      stchg_ff <= (mode_ff == CFH_MODE_IO) && !pin_stat1_in;
      csel_ff  <= !cfg_master;
    end
  end
  assign cmd_busy      = busy_ff;
  assign cmd_done      = done_ff;
  assign cmd_rdata     = rdata_ff;
  assign card_seated   = seat_ff;
  assign slave_present = slave_ff;
  assign diag_passed   = diag_ff;
  assign status_change = stchg_ff;
  assign pin_a         = a_ff;
  assign pin_ce1_n     = ce1_ff;
  assign pin_ce2_n     = ce2_ff;
  assign pin_oe_n      = oe_ff;
  assign pin_we_n      = we_ff;
  assign pin_iord_n    = iord_ff;
  assign pin_iowr_n    = iowr_ff;
  assign pin_reg_n     = reg_ff;
  assign pin_csel_n    = csel_ff;
  assign pin_d_out     = dout_ff;
  assign pin_d_oe_lo   = dlo_ff;
  assign pin_d_oe_hi   = dhi_ff;
  assign pin_stat1_out = 1'b0;
  assign pin_stat1_oe  = 1'b0;
  assign pin_stat2_out = 1'b0;
  assign pin_stat2_oe  = 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_ide_addr;
    @(posedge mclk) disable iff (!arst_n)
    (mode_ff == CFH_MODE_IDE) |-> (pin_a[10:3] == 8'h00);
  endproperty
  a_ide_addr: assert property (p_ide_addr) else $error("IDE high address not grounded");
  property p_ide_oe;
    @(posedge mclk) disable iff (!arst_n)
    (mode_ff == CFH_MODE_IDE) && cmd_busy |-> !pin_oe_n;
  endproperty
  a_ide_oe: assert property (p_ide_oe) else $error("IDE mode select not low");
  property p_ce_idle;
    @(posedge mclk) disable iff (!arst_n)
    $fell(cmd_busy) |-> pin_ce1_n && pin_ce2_n;
  endproperty
  a_ce_idle: assert property (p_ce_idle) else $error("Card left selected when idle");
  property p_wr_hold;
    @(posedge mclk) disable iff (!arst_n)
    $rose(pin_iowr_n) |-> pin_d_oe_lo && $stable(pin_d_out) ##1 pin_d_oe_lo;
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("Write data released at strobe edge");
  property p_seated;
    @(posedge mclk) disable iff (!arst_n)
    (!pin_cd1_n && !pin_cd2_n) [*2] |-> card_seated;
  endproperty
  a_seated: assert property (p_seated) else $error("Seated flag missing");
  property p_tf_byte;
    @(posedge mclk) disable iff (!arst_n)
    (mode_ff == CFH_MODE_IDE) && cmd_busy && (pin_a[2:0] != 3'h0) |-> !pin_d_oe_hi;
  endproperty
  a_tf_byte: assert property (p_tf_byte) else $error("Task file access drove high lane");
  property p_space;
    @(posedge mclk) disable iff (!arst_n)
    cmd_req && !cmd_busy && (cmd_mode == CFH_MODE_MEM) |=> (pin_reg_n == !$past(cmd_attr));
  endproperty
  a_space: assert property (p_space) else $error("Space select wrong");
  property p_cs_pick;
    @(posedge mclk) disable iff (!arst_n)
    cmd_req && !cmd_busy && (cmd_mode == CFH_MODE_IDE) |=>
      (pin_ce1_n != pin_ce2_n) && (pin_ce1_n == $past(cmd_alt));
  endproperty
  a_cs_pick: assert property (p_cs_pick) else $error("Wrong IDE chip select");
  property p_done;
    @(posedge mclk) disable iff (!arst_n)
    cmd_req && !cmd_busy |=> cmd_busy ##[14:16] cmd_done;
  endproperty
  a_done: assert property (p_done) else $error("Access did not complete in time");

endmodule
`default_nettype wire

// file: src/cfh_pkg.sv
// Purpose: Constants for the host-side card signal controller
// Assumes: 125 MHz mclk, one command at a time
// Notes:   Overview list below names the behaviour kept by the host
//
// Overview of operation
// - IDE uses A2..A0; host grounds the rest
// - Diagnostic pin is two-way in IDE mode; host only reads it
// - Active/slave-present pin is two-way in IDE; host only reads it
// - Both card detects low means card seated
// - Card enables select card and byte/word width
// - First select task file, second alternate regs
// - Sixteen data lines, D00 even, D08 odd
// - IDE registers byte on low lane, data word
// - Register select high common, low attribute
// - Host grounds output enable for IDE mode
package cfh_pkg;

  typedef enum logic [1:0] {
    CFH_MODE_MEM = 2'h0,
    CFH_MODE_IO  = 2'h1,
    CFH_MODE_IDE = 2'h2
  } cfh_mode_t;

  typedef enum logic [3:0] {
    CFH_ST_IDLE   = 4'h1,
    CFH_ST_SETUP  = 4'h2,
    CFH_ST_STROBE = 4'h4,
    CFH_ST_HOLD   = 4'h8
  } cfh_state_t;

  localparam int CFH_CLK_NS   = 8;
  // Each phase (setup, strobe, hold) lasts at least this long
  localparam int CFH_PHASE_NS = 40;
  localparam int CFH_PHASE_CYC = (CFH_PHASE_NS + CFH_CLK_NS - 1) / CFH_CLK_NS;

  localparam int CFH_ADDR_W  = 11;
  localparam int CFH_IDE_A_W = 3;
  localparam int CFH_DATA_W  = 16;
  localparam int CFH_BYTE_W  = 8;

endpackage

// file: src/cfh_tick.sv
// Purpose: Phase enable divider for the strobe sequencer
// Assumes: clr held while idle so every phase is full length
// Notes:   tick is a one-cycle pulse every CFH_PHASE_CYC cycles
`timescale 1ns/1ns
`default_nettype none
module cfh_tick
  import cfh_pkg::*;
(
  input  wire logic mclk,   // System clock
  input  wire logic arst_n, // Async reset, low
  input  wire logic clr,    // Restart count
  output logic      tick    // Phase enable pulse
);

  localparam logic [3:0] LAST = 4'(CFH_PHASE_CYC - 1);

  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic       tick_ff;
  logic       nxt_tick;

  always_comb
  begin
    nxt_tick = 1'b0;
    nxt_cnt  = cnt_ff + 4'h1;
    if (clr)
    begin
      nxt_cnt = 4'h0;
    end
    else if (cnt_ff == LAST)
    begin
      nxt_cnt  = 4'h0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_ff  <= 4'h0;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule
`default_nettype wire
